// File: ddr3pf_pkg.sv
package ddr3pf_pkg;

  // bus geometry
  localparam int BA_W      = 3;
  localparam int ADDR_W    = 13;
  localparam int NUM_BANKS = 8;
  localparam int LANES     = 2;
  localparam int BYTE_W    = 8;
  localparam int DQ_W      = LANES * BYTE_W;

  // multiplexed address bits
  localparam int AP_BIT   = 10;
  localparam int BC_BIT   = 12;
  localparam int LINE_LSB = 3;
  localparam int LINE_W   = 3;
  localparam int BEAT_W   = 3;
  localparam int MEM_AW   = BA_W + LINE_W + BEAT_W;

  // burst lengths as last beat index
  localparam logic [BEAT_W-1:0] BEAT_ZERO     = 3'h0;
  localparam logic [BEAT_W-1:0] BEAT_ONE      = 3'h1;
  localparam logic [BEAT_W-1:0] LAST_BEAT_BL8 = 3'h7;
  localparam logic [BEAT_W-1:0] LAST_BEAT_BC4 = 3'h3;

  // latencies in link clock cycles spent waiting in ST_LAT before the first beat
  localparam logic [2:0] READ_LAT  = 3'h2;
  localparam logic [2:0] WRITE_LAT = 3'h1;
  localparam logic [2:0] LAT_DONE  = 3'h1;

  localparam logic [NUM_BANKS-1:0] BANKS_NONE = 8'h00;
  localparam logic [NUM_BANKS-1:0] BANKS_ALL  = 8'hff;
  localparam logic [NUM_BANKS-1:0] BANK_ONE   = 8'h01;

  // {ras_n, cas_n, we_n} opcodes with chip select low
  localparam logic [2:0] OP_MRS = 3'h0;
  localparam logic [2:0] OP_REF = 3'h1;
  localparam logic [2:0] OP_PRE = 3'h2;
  localparam logic [2:0] OP_ACT = 3'h3;
  localparam logic [2:0] OP_WR  = 3'h4;
  localparam logic [2:0] OP_RD  = 3'h5;
  localparam logic [2:0] OP_ZQ  = 3'h6;
  localparam logic [2:0] OP_NOP = 3'h7;

  typedef enum logic [3:0] {
    CMD_NONE = 4'h0,
    CMD_ACT  = 4'h1,
    CMD_RD   = 4'h2,
    CMD_WR   = 4'h3,
    CMD_PRE  = 4'h4,
    CMD_REF  = 4'h5,
    CMD_MRS  = 4'h6,
    CMD_ZQ   = 4'h7,
    CMD_NOP  = 4'h8
  } ddr3pf_cmd_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_LAT  = 4'b0010,
    ST_RD   = 4'b0100,
    ST_WR   = 4'b1000
  } ddr3pf_state_t;

  typedef struct packed {
    logic              cs_n;
    logic              ras_n;
    logic              cas_n;
    logic              we_n;
    logic              cke;
    logic [BA_W-1:0]   ba;
    logic [ADDR_W-1:0] addr;
  } ddr3pf_pins_t;

  localparam ddr3pf_pins_t PINS_IDLE = '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1,
                                         we_n: 1'b1, cke: 1'b0, ba: 3'h0,
                                         addr: 13'h0000};

  // one decoded event handed to the core domain
  typedef struct packed {
    ddr3pf_cmd_t          kind;
    logic [BA_W-1:0]      bank;
    logic                 auto_pre;
    logic                 chop;
    logic                 all_banks;
    logic                 ap_done;
    logic [BA_W-1:0]      ap_bank;
    logic [NUM_BANKS-1:0] bank_open;
  } ddr3pf_event_t;

  localparam ddr3pf_event_t EVENT_IDLE = '{kind: CMD_NONE, bank: 3'h0, auto_pre: 1'b0,
                                           chop: 1'b0, all_banks: 1'b0, ap_done: 1'b0,
                                           ap_bank: 3'h0, bank_open: 8'h00};

endpackage

// File: ddr3pf_store.sv
`timescale 1ns/10ps
module ddr3pf_store
  import ddr3pf_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic [LANES-1:0]  we_i,
  input  wire logic [MEM_AW-1:0] addr_i,
  input  wire logic [DQ_W-1:0]   wdata_i,
  output logic      [DQ_W-1:0]   rdata_o
);

  // no reset on the array: contents are kept across a reset
  logic [DQ_W-1:0] mem [2**MEM_AW];

  // byte-lane writes, registered read
  generate
    for (genvar i = 0; i < LANES; i++)
    begin : g_lane
      always_ff @(posedge clk_i)
      begin
        if (we_i[i])
        begin
          mem[addr_i][i*BYTE_W +: BYTE_W] <= wdata_i[i*BYTE_W +: BYTE_W];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_i)
  begin
    rdata_o <= mem[addr_i];
  end

endmodule

// File: ddr3pf_top.sv
`timescale 1ns/10ps
module ddr3pf_top
  import ddr3pf_pkg::*;
(
  input  wire logic                 ref_clk_i,
  input  wire logic                 reset_n_i,
  input  wire logic                 ce_i,
  input  wire logic                 link_clk_i,
  input  wire logic                 cs_n_i,
  input  wire logic                 ras_n_i,
  input  wire logic                 cas_n_i,
  input  wire logic                 we_n_i,
  input  wire logic                 cke_i,
  input  wire logic [BA_W-1:0]      ba_i,
  input  wire logic [ADDR_W-1:0]    addr_i,
  input  wire logic [DQ_W-1:0]      dq_i,
  input  wire logic [LANES-1:0]     dm_i,
  input  wire logic [LANES-1:0]     dqs_t_i,
  input  wire logic [LANES-1:0]     dqs_c_i,
  input  wire logic                 burst_otf_en_i,
  input  wire logic                 fixed_chop_i,
  output logic      [DQ_W-1:0]      dq_o,
  output logic      [LANES-1:0]     dq_oe_n_o,
  output logic      [LANES-1:0]     dqs_t_o,
  output logic      [LANES-1:0]     dqs_c_o,
  output logic      [LANES-1:0]     dqs_oe_n_o,
  output logic                      cmd_valid_o,
  output ddr3pf_event_t             cmd_o,
  output logic      [NUM_BANKS-1:0] bank_open_o,
  output logic                      strobe_err_o
);

  // command opcode decode; an unselected or clock-disabled edge yields nothing
  function automatic ddr3pf_cmd_t cmd_decode(input ddr3pf_pins_t p, input logic cke_prev);
    ddr3pf_cmd_t k;
    k = CMD_NONE;
    if (!p.cs_n && cke_prev && p.cke)
    begin
      case ({p.ras_n, p.cas_n, p.we_n})
        OP_MRS:  k = CMD_MRS;
        OP_REF:  k = CMD_REF;
        OP_PRE:  k = CMD_PRE;
        OP_ACT:  k = CMD_ACT;
        OP_WR:   k = CMD_WR;
        OP_RD:   k = CMD_RD;
        OP_ZQ:   k = CMD_ZQ;
        default: k = CMD_NOP;
      endcase
    end
    return k;
  endfunction

  // link reset: asserts at once, releases on the link clock
  logic link_rst_meta;
  logic link_rst_n;

  always_ff @(posedge link_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      link_rst_meta <= 1'b0;
      link_rst_n    <= 1'b0;
    end
    else
    begin
      link_rst_meta <= 1'b1;
      link_rst_n    <= link_rst_meta;
    end
  end

  // core-side burst settings into the link domain
  logic otf_meta;
  logic otf_sync;
  logic chop_meta;
  logic chop_sync;

  always_ff @(posedge link_clk_i or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      otf_meta  <= 1'b0;
      otf_sync  <= 1'b0;
      chop_meta <= 1'b0;
      chop_sync <= 1'b0;
    end
    else
    begin
      otf_meta  <= burst_otf_en_i;
      otf_sync  <= otf_meta;
      chop_meta <= fixed_chop_i;
      chop_sync <= chop_meta;
    end
  end

  // command pins registered on the rising link edge
  ddr3pf_pins_t pins_q;
  logic         cke_prev;

  always_ff @(posedge link_clk_i or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      pins_q   <= PINS_IDLE;
      cke_prev <= 1'b0;
    end
    else
    begin
      pins_q   <= '{cs_n: cs_n_i, ras_n: ras_n_i, cas_n: cas_n_i, we_n: we_n_i,
                    cke: cke_i, ba: ba_i, addr: addr_i};
      cke_prev <= pins_q.cke;
    end
  end

  // burst sequencer, bank tracking and event capture
  ddr3pf_state_t        state;
  ddr3pf_state_t        next_state;
  logic [2:0]           lat_cnt;
  logic [2:0]           next_lat_cnt;
  logic                 is_read;
  logic                 next_is_read;
  logic [BA_W-1:0]      bst_bank;
  logic [BA_W-1:0]      next_bst_bank;
  logic [LINE_W-1:0]    bst_line;
  logic [LINE_W-1:0]    next_bst_line;
  logic                 bst_ap;
  logic                 next_bst_ap;
  logic [BEAT_W-1:0]    beat;
  logic [BEAT_W-1:0]    next_beat;
  logic [BEAT_W-1:0]    last_beat;
  logic [BEAT_W-1:0]    next_last_beat;
  logic [NUM_BANKS-1:0] bank_open;
  logic [NUM_BANKS-1:0] next_bank_open;
  ddr3pf_event_t        ev_data;
  ddr3pf_event_t        next_ev_data;
  logic                 ev_toggle;
  logic                 next_ev_toggle;
  ddr3pf_cmd_t          cmd_k;
  logic                 chop_now;
  logic                 ap_done;

  always_comb
  begin
    cmd_k          = cmd_decode(pins_q, cke_prev);
    chop_now       = otf_sync ? !pins_q.addr[BC_BIT] : chop_sync;
    ap_done        = 1'b0;
    next_state     = state;
    next_lat_cnt   = lat_cnt;
    next_is_read   = is_read;
    next_bst_bank  = bst_bank;
    next_bst_line  = bst_line;
    next_bst_ap    = bst_ap;
    next_beat      = beat;
    next_last_beat = last_beat;
    next_bank_open = bank_open;
    next_ev_data   = ev_data;
    next_ev_toggle = ev_toggle;
    case (state)
      ST_IDLE:
      begin
        if (cmd_k == CMD_RD || cmd_k == CMD_WR)
        begin
          next_state     = ST_LAT;
          next_is_read   = (cmd_k == CMD_RD);
          next_lat_cnt   = (cmd_k == CMD_RD) ? READ_LAT : WRITE_LAT;
          next_bst_bank  = pins_q.ba;
          next_bst_line  = pins_q.addr[LINE_LSB +: LINE_W];
          next_bst_ap    = pins_q.addr[AP_BIT];
          next_beat      = BEAT_ZERO;
          next_last_beat = chop_now ? LAST_BEAT_BC4 : LAST_BEAT_BL8;
        end
      end
      ST_LAT:
      begin
        if (lat_cnt == LAT_DONE)
        begin
          next_state = is_read ? ST_RD : ST_WR;
        end
        else
        begin
          next_lat_cnt = lat_cnt - LAT_DONE;
        end
      end
      default:
      begin
        next_beat = beat + BEAT_ONE;
        if (beat == last_beat)
        begin
          next_state = ST_IDLE;
          ap_done    = bst_ap;
        end
      end
    endcase
    // bank open state; auto-precharge first so a same-edge activate wins
    if (ap_done)
    begin
      next_bank_open = next_bank_open & ~(BANK_ONE << bst_bank);
    end
    if (cmd_k == CMD_ACT)
    begin
      next_bank_open = next_bank_open | (BANK_ONE << pins_q.ba);
    end
    else if (cmd_k == CMD_PRE)
    begin
      next_bank_open = pins_q.addr[AP_BIT] ? BANKS_NONE
                     : (next_bank_open & ~(BANK_ONE << pins_q.ba));
    end
    // every real command or burst-end close is reported once
    if ((cmd_k != CMD_NONE && cmd_k != CMD_NOP) || ap_done)
    begin
      next_ev_data   = '{kind: (cmd_k == CMD_NOP) ? CMD_NONE : cmd_k, bank: pins_q.ba,
                         auto_pre: pins_q.addr[AP_BIT], chop: chop_now,
                         all_banks: (cmd_k == CMD_PRE) && pins_q.addr[AP_BIT],
                         ap_done: ap_done, ap_bank: bst_bank, bank_open: next_bank_open};
      next_ev_toggle = !ev_toggle;
    end
  end

  always_ff @(posedge link_clk_i or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      state     <= ST_IDLE;
      lat_cnt   <= READ_LAT;
      is_read   <= 1'b0;
      bst_bank  <= 3'h0;
      bst_line  <= 3'h0;
      bst_ap    <= 1'b0;
      beat      <= BEAT_ZERO;
      last_beat <= LAST_BEAT_BL8;
      bank_open <= BANKS_NONE;
      ev_data   <= EVENT_IDLE;
      ev_toggle <= 1'b0;
    end
    else
    begin
      state     <= next_state;
      lat_cnt   <= next_lat_cnt;
      is_read   <= next_is_read;
      bst_bank  <= next_bst_bank;
      bst_line  <= next_bst_line;
      bst_ap    <= next_bst_ap;
      beat      <= next_beat;
      last_beat <= next_last_beat;
      bank_open <= next_bank_open;
      ev_data   <= next_ev_data;
      ev_toggle <= next_ev_toggle;
    end
  end

  // data store, shared by both lanes, one beat per link cycle
  logic [LANES-1:0]  lane_we;
  logic [LANES-1:0]  lane_bad;
  logic [DQ_W-1:0]   mem_q;
  logic [MEM_AW-1:0] mem_addr;

  assign mem_addr = {bst_bank, bst_line, beat};

  ddr3pf_store u_store (
    .clk_i   (link_clk_i),
    .we_i    (lane_we),
    .addr_i  (mem_addr),
    .wdata_i (dq_i),
    .rdata_o (mem_q)
  );

  // read pipeline: store output is one cycle behind the issued beat
  logic rd_p1;
  logic rd_phase;
  logic strobe_bad;
  logic next_strobe_bad;

  always_comb
  begin
    next_strobe_bad = strobe_bad | (|lane_bad); // sticky until reset
  end

  always_ff @(posedge link_clk_i or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      rd_p1      <= 1'b0;
      rd_phase   <= 1'b0;
      strobe_bad <= 1'b0;
    end
    else
    begin
      rd_p1      <= (state == ST_RD);
      rd_phase   <= beat[0];
      strobe_bad <= next_strobe_bad;
    end
  end

  // per-lane write capture and read drive; mask and strobe checked per lane, read timing shared by both lanes
  generate
    for (genvar i = 0; i < LANES; i++)
    begin : g_lane
      logic [BYTE_W-1:0] next_dq;
      logic              next_dqs_t;

      // write beat only with a proper complementary strobe pair
      assign lane_we[i]  = (state == ST_WR) && !dm_i[i]
                           && (dqs_t_i[i] != dqs_c_i[i]);
      assign lane_bad[i] = (state == ST_WR) && (dqs_t_i[i] == dqs_c_i[i]);

      always_comb
      begin
        next_dq    = rd_p1 ? mem_q[i*BYTE_W +: BYTE_W] : dq_o[i*BYTE_W +: BYTE_W];
        next_dqs_t = rd_p1 && !rd_phase;
      end

      always_ff @(posedge link_clk_i or negedge link_rst_n)
      begin
        if (!link_rst_n)
        begin
          dq_o[i*BYTE_W +: BYTE_W] <= 8'h00;
          dq_oe_n_o[i]             <= 1'b1;
          dqs_t_o[i]               <= 1'b0;
          dqs_c_o[i]               <= 1'b1;
          dqs_oe_n_o[i]            <= 1'b1;
        end
        else
        begin
          dq_o[i*BYTE_W +: BYTE_W] <= next_dq;
          dq_oe_n_o[i]             <= !rd_p1;
          dqs_t_o[i]               <= next_dqs_t;
          dqs_c_o[i]               <= !next_dqs_t;
          dqs_oe_n_o[i]            <= !rd_p1;
        end
      end
    end
  endgenerate

  // core side: event toggle and error level cross on two flops
  logic ev_meta;
  logic ev_sync;
  logic ev_seen;
  logic err_meta;
  logic err_sync;

  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      ev_meta  <= 1'b0;
      ev_sync  <= 1'b0;
      err_meta <= 1'b0;
      err_sync <= 1'b0;
    end
    else if (ce_i)
    begin
      ev_meta  <= ev_toggle;
      ev_sync  <= ev_meta;
      err_meta <= strobe_bad;
      err_sync <= err_meta;
    end
  end

  // event data is stable a full link cycle, long past the toggle's arrival
  logic                 next_cmd_valid;
  ddr3pf_event_t        next_cmd;
  logic [NUM_BANKS-1:0] next_bank_open_o;

  always_comb
  begin
    next_cmd_valid   = (ev_sync != ev_seen);
    next_cmd         = next_cmd_valid ? ev_data : cmd_o;
    next_bank_open_o = next_cmd_valid ? ev_data.bank_open : bank_open_o;
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      ev_seen      <= 1'b0;
      cmd_valid_o  <= 1'b0;
      cmd_o        <= EVENT_IDLE;
      bank_open_o  <= BANKS_NONE;
      strobe_err_o <= 1'b0;
    end
    else if (ce_i)
    begin
      ev_seen      <= ev_sync;
      cmd_valid_o  <= next_cmd_valid;
      cmd_o        <= next_cmd;
      bank_open_o  <= next_bank_open_o;
      strobe_err_o <= err_sync;
    end
  end

endmodule

// File: ddr3pf_properties.sv
`timescale 1ns/10ps
// pin-level protocol watch on the device outputs
module ddr3pf_properties
  import ddr3pf_pkg::*;
(
  input wire logic                 ref_clk_i,
  input wire logic                 reset_n_i,
  input wire logic                 ce_i,
  input wire logic                 link_clk_i,
  input wire logic [LANES-1:0]     dq_oe_n_o,
  input wire logic [LANES-1:0]     dqs_t_o,
  input wire logic [LANES-1:0]     dqs_c_o,
  input wire logic [LANES-1:0]     dqs_oe_n_o,
  input wire logic                 cmd_valid_o,
  input wire ddr3pf_event_t        cmd_o,
  input wire logic [NUM_BANKS-1:0] bank_open_o,
  input wire logic                 strobe_err_o
);
  // link side: strobes always leave as a true/complement pair
  strobe_pair_a: assert property (@(posedge link_clk_i) disable iff (!reset_n_i)
    dqs_t_o == ~dqs_c_o) else $error("read strobe pair not complementary");
  lane_enable_a: assert property (@(posedge link_clk_i) disable iff (!reset_n_i)
    dqs_oe_n_o == dq_oe_n_o) else $error("strobe enable differs from data enable");
  // edge-aligned: first beat starts high, then one edge per beat
  first_edge_a: assert property (@(posedge link_clk_i) disable iff (!reset_n_i)
    $fell(dqs_oe_n_o[0]) |-> dqs_t_o[0]) else $error("first read strobe level wrong");
  strobe_toggle_a: assert property (@(posedge link_clk_i) disable iff (!reset_n_i)
    !dqs_oe_n_o[0] && !$past(dqs_oe_n_o[0]) |-> dqs_t_o[0] != $past(dqs_t_o[0]))
    else $error("read strobe missed an edge");
  // a burst is never longer than eight beats, so the lane must let go
  burst_release_a: assert property (@(posedge link_clk_i) disable iff (!reset_n_i)
    (!dq_oe_n_o[0]) [*8] |=> dq_oe_n_o[0]) else $error("data lane held past a burst");
  err_sticky_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    strobe_err_o |=> strobe_err_o) else $error("strobe error flag dropped");
  // core side: events and bank state
  valid_pulse_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    cmd_valid_o && ce_i |=> !cmd_valid_o) else $error("event valid longer than a cycle");
  bank_hold_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    $changed(bank_open_o) |-> cmd_valid_o) else $error("bank state moved without event");
  act_open_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    cmd_valid_o && cmd_o.kind == CMD_ACT |-> bank_open_o[cmd_o.bank])
    else $error("activated bank not open");
  all_close_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    cmd_valid_o && cmd_o.kind == CMD_PRE && cmd_o.auto_pre
    |-> cmd_o.all_banks && bank_open_o == BANKS_NONE) else $error("close-all left a bank");
  ap_close_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    cmd_valid_o && cmd_o.ap_done && cmd_o.kind != CMD_ACT |-> !bank_open_o[cmd_o.ap_bank])
    else $error("auto-close left bank open");
endmodule

bind ddr3pf_top ddr3pf_properties u_props (.ref_clk_i, .reset_n_i, .ce_i, .link_clk_i,
  .dq_oe_n_o, .dqs_t_o, .dqs_c_o, .dqs_oe_n_o, .cmd_valid_o, .cmd_o, .bank_open_o,
  .strobe_err_o);

// File: ddr3pf_ctrl_model.sv
`timescale 1ns/10ps
// behavioural memory controller driving the pins on the link clock
module ddr3pf_ctrl_model
  import ddr3pf_pkg::*;
(
  input  wire logic             link_clk_i,
  input  wire logic [DQ_W-1:0]  rd_dq_i,
  input  wire logic [LANES-1:0] rd_oe_n_i,
  output ddr3pf_pins_t          pins_o,
  output logic      [DQ_W-1:0]  dq_o,
  output logic      [LANES-1:0] dm_o,
  output logic      [LANES-1:0] dqs_t_o,
  output logic      [LANES-1:0] dqs_c_o
);
  logic [DQ_W-1:0] rd_d [0:15];
  int              rd_n = 0;

  // deselected with clock enable high, so the first command is valid
  initial
  begin
    pins_o  = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 3'h0, 13'h0000};
    dq_o    = 16'h0000;
    dm_o    = 2'b00;
    dqs_t_o = 2'b00;
    dqs_c_o = 2'b11;
  end

  // one command for one link edge, then deselect with inverted address
  task automatic issue(input logic [2:0] op, input logic [BA_W-1:0] ba,
                       input logic [ADDR_W-1:0] a, input logic cs_n = 1'b0,
                       input logic cke = 1'b1);
    @(posedge link_clk_i);
    pins_o <= '{cs_n, op[2], op[1], op[0], cke, ba, a};
    @(posedge link_clk_i);
    pins_o <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, ~ba, ~a};
  endtask

  // eight beats from the third edge after the command; beat 2 may be masked
  task automatic wr(input logic [BA_W-1:0] ba, input logic [ADDR_W-1:0] a,
                    input logic [DQ_W-1:0] base, input logic [LANES-1:0] mask,
                    input logic bad);
    issue(OP_WR, ba, a);
    repeat (2) @(posedge link_clk_i);
    for (int b = 0; b < 8; b++)
    begin
      dq_o    <= base + 16'(b) * 16'h0101;
      dm_o    <= (b == 2) ? mask : 2'b00;
      dqs_t_o <= {2{~b[0]}};
      dqs_c_o <= bad ? {2{~b[0]}} : {2{b[0]}};
      @(posedge link_clk_i);
    end
    // released lines show the inverse, never a stale value
    dq_o    <= ~dq_o;
    dm_o    <= ~dm_o;
    dqs_t_o <= ~dqs_t_o;
    dqs_c_o <= ~dqs_c_o;
    repeat (2) @(posedge link_clk_i);
  endtask

  // read, then wait out latency plus the longest burst
  task automatic rd(input logic [BA_W-1:0] ba, input logic [ADDR_W-1:0] a);
    rd_n = 0;
    issue(OP_RD, ba, a);
    repeat (16) @(posedge link_clk_i);
  endtask

  // capture mid-cycle, only while the lane is driven
  always @(negedge link_clk_i)
    if (rd_oe_n_i[0] === 1'b0 && rd_n < 16)
    begin
      rd_d[rd_n] = rd_dq_i;
      rd_n++;
    end
endmodule

// File: tb.sv
`timescale 1ns/10ps
module tb;
  import ddr3pf_pkg::*;
  logic                 ref_clk    = 1'b0;
  logic                 link_clk   = 1'b0;
  logic                 reset_n    = 1'b0;
  logic                 otf_en     = 1'b1;
  logic                 fixed_chop = 1'b0;
  logic                 ce         = 1'b1;
  ddr3pf_pins_t         pins;
  logic [DQ_W-1:0]      wdq, rdq;
  logic [LANES-1:0]     dm, wdqs_t, wdqs_c, oe_n, dqs_t, dqs_c, dqs_oe_n;
  logic                 cmd_valid, strobe_err;
  ddr3pf_event_t        cmd;
  logic [NUM_BANKS-1:0] bank_open;
  int                   errors  = 0;
  int                   n_tests = 0;

  // core clock; link clock offset so edges never coincide
  always #2.5 ref_clk = ~ref_clk;
  initial
  begin
    #3.3;
    forever #16 link_clk = ~link_clk;
  end

  ddr3pf_ctrl_model ctl (.link_clk_i(link_clk), .rd_dq_i(rdq), .rd_oe_n_i(oe_n),
    .pins_o(pins), .dq_o(wdq), .dm_o(dm), .dqs_t_o(wdqs_t), .dqs_c_o(wdqs_c));

  ddr3pf_top dut (.ref_clk_i(ref_clk), .reset_n_i(reset_n), .ce_i(ce),
    .link_clk_i(link_clk), .cs_n_i(pins.cs_n), .ras_n_i(pins.ras_n), .cas_n_i(pins.cas_n),
    .we_n_i(pins.we_n), .cke_i(pins.cke), .ba_i(pins.ba), .addr_i(pins.addr), .dq_i(wdq),
    .dm_i(dm), .dqs_t_i(wdqs_t), .dqs_c_i(wdqs_c), .burst_otf_en_i(otf_en),
    .fixed_chop_i(fixed_chop), .dq_o(rdq), .dq_oe_n_o(oe_n), .dqs_t_o(dqs_t),
    .dqs_c_o(dqs_c), .dqs_oe_n_o(dqs_oe_n), .cmd_valid_o(cmd_valid), .cmd_o(cmd),
    .bank_open_o(bank_open), .strobe_err_o(strobe_err));

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  // bounded wait for an event pulse; a missing one ends the run
  task automatic evt(input logic want);
    logic seen;
    seen = 1'b0;
    repeat (40)
    begin
      @(negedge ref_clk);
      if (cmd_valid === 1'b1) seen = 1'b1;
      if (seen && want) break;
    end
    check("event", seen, want);
    if (want && !seen)
      tally_and_finish();
  endtask

  // entry is asynchronous; the long wait after release covers the link side
  task automatic apply_reset();
    @(posedge ref_clk);
    reset_n <= 1'b0;
    repeat (10) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (40) @(posedge ref_clk);
  endtask

  task automatic t_reset();
    check("dq enable", oe_n, 2'b11);
    check("dqs enable", dqs_oe_n, 2'b11);
    check("banks", bank_open, 8'h00);
    check("strobe err", strobe_err, 1'b0);
    check("dqs pair", {dqs_t, dqs_c}, 4'b0011);
  endtask

  // frozen core shows nothing; the event arrives once the enable returns
  task automatic t_freeze();
    @(posedge ref_clk);
    ce <= 1'b0;
    ctl.issue(OP_ACT, 3'h6, 13'h0000);
    evt(1'b0);
    @(posedge ref_clk);
    ce <= 1'b1;
    evt(1'b1);
    check("banks", bank_open, 8'h40);
    check("bank", cmd.bank, 3'h6);
  endtask

  task automatic t_banks();
    logic [2:0]  ops [3]   = '{OP_MRS, OP_REF, OP_ZQ};
    ddr3pf_cmd_t kinds [3] = '{CMD_MRS, CMD_REF, CMD_ZQ};
    ctl.issue(OP_ACT, 3'h2, 13'h0000);
    evt(1'b1);
    check("banks", bank_open, 8'h04);
    check("bank", cmd.bank, 3'h2);
    ctl.issue(OP_ACT, 3'h5, 13'h0000);
    evt(1'b1);
    ctl.issue(OP_ACT, 3'h3, 13'h0000, 1'b1);
    evt(1'b0);
    ctl.issue(OP_ACT, 3'h3, 13'h0000, 1'b0, 1'b0);
    evt(1'b0);
    ctl.issue(OP_NOP, 3'h3, 13'h0000);
    evt(1'b0);
    check("banks", bank_open, 8'h24);
    ctl.issue(OP_PRE, 3'h2, 13'h0000);
    evt(1'b1);
    check("banks", bank_open, 8'h20);
    ctl.issue(OP_ACT, 3'h1, 13'h0000);
    evt(1'b1);
    ctl.issue(OP_PRE, 3'h1, 13'h0400);
    evt(1'b1);
    check("all banks", cmd.all_banks, 1'b1);
    check("banks", bank_open, 8'h00);
    for (int i = 0; i < 3; i++)
    begin
      ctl.issue(ops[i], 3'h0, 13'h0000);
      evt(1'b1);
      check("kind", cmd.kind, kinds[i]);
    end
  endtask

  // lanes masked independently; burst length by address bit or fixed mode
  task automatic t_data();
    ctl.issue(OP_ACT, 3'h1, 13'h0000);
    evt(1'b1);
    ctl.wr(3'h1, 13'h1008, 16'h1030, 2'b00, 1'b0);
    ctl.wr(3'h1, 13'h1008, 16'h50c0, 2'b10, 1'b0);
    ctl.rd(3'h1, 13'h1008);
    check("beats", ctl.rd_n, 8);
    for (int b = 0; b < 8; b++)
      check("rd data", ctl.rd_d[b], (b == 2) ? 16'h12c2 : 16'h50c0 + 16'(b) * 16'h0101);
    ctl.rd(3'h1, 13'h0008);
    check("beats", ctl.rd_n, 4);
    check("rd data", ctl.rd_d[3], 16'h53c3);
    check("chop", cmd.chop, 1'b1);
    @(posedge ref_clk);
    otf_en     <= 1'b0;
    fixed_chop <= 1'b1;
    ctl.rd(3'h1, 13'h1008);
    check("beats", ctl.rd_n, 4);
    @(posedge ref_clk);
    fixed_chop <= 1'b0;
    ctl.rd(3'h1, 13'h0008);
    check("beats", ctl.rd_n, 8);
    check("banks", bank_open, 8'h02);
    @(posedge ref_clk);
    otf_en <= 1'b1;
    ctl.rd(3'h1, 13'h1408);
    check("beats", ctl.rd_n, 8);
    check("banks", bank_open, 8'h00);
    check("ap done", cmd.ap_done, 1'b1);
    check("ap bank", cmd.ap_bank, 3'h1);
  endtask

  // broken strobe pair on an auto-closing write, then reset mid-run
  task automatic t_strobe();
    ctl.issue(OP_ACT, 3'h4, 13'h0000);
    evt(1'b1);
    ctl.wr(3'h4, 13'h1400, 16'h0000, 2'b00, 1'b1);
    repeat (4) @(posedge link_clk);
    check("strobe err", strobe_err, 1'b1);
    check("banks", bank_open, 8'h00);
    apply_reset();
    t_reset();
  endtask

  initial
  begin
    apply_reset();
    t_reset();
    t_banks();
    t_data();
    t_strobe();
    t_freeze();
    tally_and_finish();
  end
endmodule
